//--- dv/sdp_host_model.sv
// Host-side model: upsampled timebase and sample supply.
`timescale 1ns/1ps
`default_nettype none
module sdp_host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_smp_req,
  output wire logic        o_os_tick,
  output wire logic [15:0] o_smp_l,
  output wire logic [15:0] o_smp_r,
  output wire logic        o_smp_valid
);
  logic [1:0]  ph_r   = 2'h0;
  logic        tick_r = 1'b0;
  logic        vld_r  = 1'b0;
  logic [15:0] smp_r  = 16'h0000;
  assign o_os_tick   = tick_r;
  assign o_smp_valid = vld_r;
  assign o_smp_l     = smp_r;
  assign o_smp_r     = ~smp_r;
  // A tick every third core cycle keeps the reference rate fixed.
  always @(posedge i_core_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      ph_r   <= 2'h0;
      tick_r <= 1'b0;
      vld_r  <= 1'b0;
      smp_r  <= 16'h0000;
    end
    else
    begin
      ph_r   <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      tick_r <= (ph_r == 2'h2);
      vld_r  <= i_smp_req;
      if (i_smp_req)
        smp_r <= smp_r + 16'h1357;
    end
endmodule
`default_nettype wire

//--- dv/sdp_top_asserts.sv
// Port-level checks for the stereo DAC digital path.
`timescale 1ns/1ps
`default_nettype none
module sdp_top_asserts (
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic [6:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        i_os_tick,
  input wire logic        i_fsref_441,
  input wire logic [15:0] i_smp_l,
  input wire logic [15:0] i_smp_r,
  input wire logic        i_smp_valid,
  input wire logic        o_smp_req,
  input wire logic [15:0] o_dac_l,
  input wire logic [15:0] o_dac_r,
  input wire logic        o_dac_valid,
  input wire logic        o_dac_pwr_l,
  input wire logic        o_dac_pwr_r
);
  default clocking dc @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  dac_valid_a: assert property (!$past(i_sys_rst) |-> o_dac_valid == $past(i_os_tick))
    else $error("output valid not one cycle after tick");
  dac_hold_a: assert property (!$past(i_sys_rst) && !o_dac_valid
    |-> $stable(o_dac_l) && $stable(o_dac_r))
    else $error("output sample moved without valid");
  req_pulse_a: assert property (o_smp_req |=> !o_smp_req)
    else $error("sample request longer than one cycle");
  req_tick_a: assert property (o_smp_req && !$past(i_sys_rst) |-> $past(i_os_tick))
    else $error("sample request not after a tick");
  step_bits_a: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 7'h04
    |-> o_reg_rdata[15:4] == 12'h000 && !o_reg_rdata[0])
    else $error("stepping register has stray bits");
  pstat_bits_a: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 7'h05
    |-> (o_reg_rdata & 16'hFBE7) == 16'h0000)
    else $error("power status has stray bits");
  pstat_on_a: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 7'h05
    && $past(o_dac_pwr_l) |-> !(o_reg_rdata[10] && o_reg_rdata[4]))
    else $error("left shown stable off while powered");
  unmap_rd_a: assert property ($past(i_reg_rd) && !($past(i_reg_addr) inside
    {7'h00, [7'h02:7'h07], 7'h1D, [7'h40:7'h53]}) |-> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind sdp_top sdp_top_asserts u_sva (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_os_tick(i_os_tick), .i_fsref_441(i_fsref_441),
  .i_smp_l(i_smp_l), .i_smp_r(i_smp_r), .i_smp_valid(i_smp_valid),
  .o_smp_req(o_smp_req), .o_dac_l(o_dac_l), .o_dac_r(o_dac_r),
  .o_dac_valid(o_dac_valid), .o_dac_pwr_l(o_dac_pwr_l), .o_dac_pwr_r(o_dac_pwr_r)
);
`default_nettype wire

//--- dv/sdp_top_bench.sv
// Self-checking bench for the stereo DAC digital path.
`timescale 1ns/1ps
`default_nettype none
module sdp_top_bench;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic [6:0]  addr = 7'h00;
  logic [15:0] wd   = 16'h0000;
  logic        wr   = 1'b0;
  logic        rd   = 1'b0;
  logic [15:0] rdata, sl, sr, dl, dr, d;
  logic        tick, sv, req, dv, pl, pr;
  logic [6:0]  ra;
  logic [15:0] crst [5] = '{16'h6BE3, 16'h9666, 16'h675D, 16'h7D83, 16'h84EE};
  logic [15:0] per [8] = '{16'h80, 16'hC0, 16'h100, 16'h180,
                           16'h200, 16'h280, 16'h2C0, 16'h300};
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  sdp_top DUT (
    .i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_os_tick(tick),
    .i_fsref_441(1'b0), .i_smp_l(sl), .i_smp_r(sr), .i_smp_valid(sv),
    .o_smp_req(req), .o_dac_l(dl), .o_dac_r(dr), .o_dac_valid(dv),
    .o_dac_pwr_l(pl), .o_dac_pwr_r(pr)
  );
  sdp_host_model u_host (
    .i_core_clk(clk), .i_sys_rst(rst), .i_smp_req(req), .o_os_tick(tick),
    .o_smp_l(sl), .o_smp_r(sr), .o_smp_valid(sv)
  );
  always #5 clk = ~clk;
  task automatic close_out;
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [6:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wd   <= v;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [6:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] v;
    rreg(a, v);
    chk(v, e);
  endtask
  task automatic wait_req;
    int g;
    g = 0;
    do
    begin
      @(negedge clk);
      g++;
    end while (req !== 1'b1 && g < 9000);
  endtask
  // Reads once per sample request until the value shows; n counts requests.
  task automatic poll(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] v;
    n = 0;
    rreg(a, v);
    while (v !== e && n < 60)
    begin
      wait_req();
      n++;
      rreg(a, v);
    end
    chk(v, e);
  endtask
  initial
  begin
    #950000;
    err_total++;
    close_out();
  end
  initial
  begin
    d = 16'($urandom(32'h362bcd97));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20; i++)
      rchk(7'h40 + 7'(i), crst[i % 5]);
    rchk(7'h05, 16'h0418);
    rchk(7'h07, 16'h0010);
    rchk(7'h1D, 16'h0000);
    rchk(7'h06, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      ra = 7'h40 + 7'($urandom % 20);
      d  = 16'($urandom);
      wreg(ra, d);
      rchk(ra, d);
    end
    wreg(7'h03, d);
    rchk(7'h02, {d[7:0], d[7:0]});
    wreg(7'h05, d);
    rchk(7'h05, 16'h0418);
    rchk(7'h01, 16'h0000);
    wreg(7'h02, 16'h7878);
    wreg(7'h07, 16'h0003);
    wreg(7'h06, 16'h000C);
    rchk(7'h05, 16'h0018);
    wait_req();
    rchk(7'h05, 16'h0018);
    poll(7'h05, 16'h0000);
    poll(7'h04, 16'h000C);
    wreg(7'h02, 16'h7070);
    poll(7'h04, 16'h000C);
    chk(16'(n), 16'h8);
    wreg(7'h04, 16'hFFFF);
    rchk(7'h04, 16'h000E);
    wreg(7'h02, 16'h7878);
    poll(7'h04, 16'h000E);
    chk(16'((n + 1) / 2), 16'h8);
    wreg(7'h1D, 16'h4000);
    wreg(7'h02, 16'h7070);
    rchk(7'h04, 16'h000E);
    wreg(7'h1D, 16'h0000);
    wreg(7'h04, 16'h0000);
    wreg(7'h06, 16'h000E);
    rchk(7'h04, 16'h0000);
    poll(7'h04, 16'h000C);
    wreg(7'h06, 16'h0002);
    rchk(7'h05, 16'h0400);
    poll(7'h05, 16'h0418);
    // Sixteen steps to mute; the off state shows a cycle after the last one,
    // so the poll sees it one request later.
    chk(16'(n), 16'h11);
    chk({14'h0, pl, pr}, 16'h0000);
    for (int c = 0; c < 8; c++)
    begin
      wreg(7'h00, 16'(c << 3));
      rchk(7'h00, 16'(c << 3));
      wait_req();
      wait_req();
      n = 0;
      do
      begin
        @(negedge clk);
        n += int'(tick);
      end while (req !== 1'b1 && n < 900);
      chk(16'(n), per[c]);
    end
    close_out();
  end
endmodule
`default_nettype wire

//--- pkg/sdp_defines.vh
// Constants for the stereo DAC digital playback path.
`ifndef SDP_DEFINES_VH
`define SDP_DEFINES_VH
`define SDP_REG_RATE      7'h00
`define SDP_REG_VOLS      7'h02
`define SDP_REG_MVOL      7'h03
`define SDP_REG_STEP      7'h04
`define SDP_REG_PSTAT     7'h05
`define SDP_REG_CTRL      7'h06
`define SDP_REG_UPDLY     7'h07
`define SDP_REG_SSDIS     7'h1D
`define SDP_REG_COEF0     7'h40
`define SDP_REG_COEF_END  7'h54
`define SDP_DIV_MSB       5
`define SDP_DIV_LSB       3
`define SDP_SLOW_BIT      1
`define SDP_DONE_L_BIT    3
`define SDP_DONE_R_BIT    2
`define SDP_DIR_BIT       10
`define SDP_PST_L_BIT     4
`define SDP_PST_R_BIT     3
`define SDP_SSDIS_BIT     14
`define SDP_CTL_DEEMPH    0
`define SDP_CTL_FX        1
`define SDP_CTL_PWR_L     2
`define SDP_CTL_PWR_R     3
`define SDP_UPDLY_RST     16'h0010
// Last upsampled tick count of a reference sample (128 ticks), and upsampled ticks per DAC sample for each divider code.
`define SDP_OS_PER_FSREF  7'h7F
`define SDP_PER_D0        10'h080
`define SDP_PER_D1        10'h0C0
`define SDP_PER_D2        10'h100
`define SDP_PER_D3        10'h180
`define SDP_PER_D4        10'h200
`define SDP_PER_D5        10'h280
`define SDP_PER_D6        10'h2C0
`define SDP_PER_D7        10'h300
`define SDP_DIV_1         3'h0
`define SDP_DIV_1P5       3'h1
// Effects filter reset coefficients, Q15.
`define SDP_B0_RST        16'h6BE3
`define SDP_B1_RST        16'h9666
`define SDP_B2_RST        16'h675D
`define SDP_A1_RST        16'h7D83
`define SDP_A2_RST        16'h84EE
`define SDP_NCOEF         5
`define SDP_CH_COEFS      10
`define SDP_Q             15
`define SDP_ZERO16        16'h0000
// De-emphasis time constants in microseconds, and bilinear Q15 coefficients
// per rate (numerator tap 1 and pole halved for the biquad form).
`define SDP_DE_POLE_US    50
`define SDP_DE_ZERO_US    15
`define SDP_DE48_B0       16'h35D9
`define SDP_DE48_B1       16'hFB25
`define SDP_DE48_A1       16'h29EF
`define SDP_DE44_B0       16'h36F6
`define SDP_DE44_B1       16'hFC2E
`define SDP_DE44_A1       16'h2857
`define SDP_DE32_B0       16'h3BBC
`define SDP_DE32_B1       16'h009C
`define SDP_DE32_A1       16'h2186
// Volume: index 0 is 0 dB, each step 0.5 dB down, index 128 is mute.
`define SDP_MUTE_IDX      8'h80
`define SDP_STEPS_6DB     8'h0C
`define SDP_GAIN_0        16'h7FFF
`define SDP_GAIN_1        16'h78D6
`define SDP_GAIN_2        16'h7214
`define SDP_GAIN_3        16'h6BB3
`define SDP_GAIN_4        16'h65AC
`define SDP_GAIN_5        16'h5FFD
`define SDP_GAIN_6        16'h5A9E
`define SDP_GAIN_7        16'h558C
`define SDP_GAIN_8        16'h50C3
`define SDP_GAIN_9        16'h4C3F
`define SDP_GAIN_10       16'h47FB
`define SDP_GAIN_11       16'h43F4
`define SDP_DLY_TAPS      17
`define SDP_INTERP_SH     2
`define SDP_PST_OFF       2'b00
`define SDP_PST_UP        2'b01
`define SDP_PST_ON        2'b10
`define SDP_PST_DOWN      2'b11
`endif

//--- rtl/sdp_top.v
// Stereo DAC digital path: de-emphasis, effects biquads, volume, interpolation.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sdp_defines.vh"

module sdp_biquad (
  input  wire        i_core_clk,
  input  wire        i_sys_rst,
  input  wire        i_en,
  input  wire        i_byp,
  input  wire [15:0] i_x,
  input  wire [15:0] i_b0,
  input  wire [15:0] i_b1,
  input  wire [15:0] i_b2,
  input  wire [15:0] i_a1,
  input  wire [15:0] i_a2,
  output reg  [15:0] o_y
);
  reg  signed [15:0] x1_r;
  reg  signed [15:0] x2_r;
  reg  signed [15:0] y1_r;
  reg  signed [15:0] y2_r;
  wire signed [35:0] acc;
  wire signed [35:0] sh;
  wire        [15:0] y_sat;

  assign acc = $signed(i_b0) * $signed(i_x)
             + (($signed(i_b1) * x1_r) <<< 1)
             + $signed(i_b2) * x2_r
             + (($signed(i_a1) * y1_r) <<< 1)
             + $signed(i_a2) * y2_r;
  assign sh = acc >>> `SDP_Q;
  assign y_sat = (&sh[35:15] | ~|sh[35:15]) ? sh[15:0]
               : (sh[35] ? 16'h8000 : 16'h7FFF);

  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      x1_r <= 16'h0000;
      x2_r <= 16'h0000;
      y1_r <= 16'h0000;
      y2_r <= 16'h0000;
      o_y  <= 16'h0000;
    end
    else if (i_en)
    begin
      x1_r <= i_x;
      x2_r <= x1_r;
      y1_r <= y_sat;
      y2_r <= y1_r;
      o_y  <= i_byp ? i_x : y_sat;
    end
  end
endmodule

module sdp_vol_ctl (
  input  wire        i_core_clk,
  input  wire        i_sys_rst,
  input  wire        i_step,
  input  wire        i_ss_dis,
  input  wire [7:0]  i_req_idx,
  input  wire        i_force_mute,
  input  wire        i_pwr_req,
  input  wire        i_fsref_tick,
  input  wire [15:0] i_up_dly,
  output wire [7:0]  o_cur_idx,
  output wire [1:0]  o_state,
  output wire        o_done
);
  reg  [7:0]  cur_r;
  reg  [1:0]  st_r;
  reg  [15:0] dly_cnt_r;
  wire [7:0]  eff_tgt;

  assign eff_tgt = (i_force_mute || st_r != `SDP_PST_ON) ? `SDP_MUTE_IDX : i_req_idx;
  assign o_cur_idx = cur_r;
  assign o_state = st_r;
  // A filter switch in progress is not finished stepping, even at the mute point.
  assign o_done = (cur_r == eff_tgt) && !i_force_mute;

  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cur_r <= `SDP_MUTE_IDX;
    else if (i_ss_dis)
      cur_r <= eff_tgt;
    else if (i_step && cur_r < eff_tgt)
      cur_r <= cur_r + 8'h01;
    else if (i_step && cur_r > eff_tgt)
      cur_r <= cur_r - 8'h01;
  end

  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= `SDP_PST_OFF;
      dly_cnt_r <= 16'h0000;
    end
    else
    begin
      case (st_r)
        `SDP_PST_OFF:
        begin
          dly_cnt_r <= 16'h0000;
          if (i_pwr_req)
            st_r <= `SDP_PST_UP;
        end
        `SDP_PST_UP:
        begin
          if (!i_pwr_req)
            st_r <= `SDP_PST_DOWN;
          else if (dly_cnt_r >= i_up_dly)
            st_r <= `SDP_PST_ON;
          else if (i_fsref_tick)
            dly_cnt_r <= dly_cnt_r + 16'h0001;
        end
        `SDP_PST_ON:
        begin
          if (!i_pwr_req)
            st_r <= `SDP_PST_DOWN;
        end
        `SDP_PST_DOWN:
        begin
          if (cur_r == `SDP_MUTE_IDX)
            st_r <= `SDP_PST_OFF;
        end
        default:
          st_r <= `SDP_PST_OFF;
      endcase
    end
  end
endmodule

module sdp_top (
  input  wire        i_core_clk,
  input  wire        i_sys_rst,
  input  wire [6:0]  i_reg_addr,
  input  wire [15:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [15:0] o_reg_rdata,
  input  wire        i_os_tick,
  input  wire        i_fsref_441,
  input  wire [15:0] i_smp_l,
  input  wire [15:0] i_smp_r,
  input  wire        i_smp_valid,
  output wire        o_smp_req,
  output wire [15:0] o_dac_l,
  output wire [15:0] o_dac_r,
  output reg         o_dac_valid,
  output wire        o_dac_pwr_l,
  output wire        o_dac_pwr_r
);
  reg  [2:0]  div_code_r;
  reg  [7:0]  vol_l_r;
  reg  [7:0]  vol_r_r;
  reg         slow_r;
  reg         ss_dis_r;
  reg         deemph_req_r;
  reg         fx_req_r;
  reg         deemph_act_r;
  reg         fx_act_r;
  reg         pwr_l_r;
  reg         pwr_r_r;
  reg  [15:0] up_dly_r;
  reg  [15:0] coef_r [0:19];
  reg  [15:0] in_l_r;
  reg  [15:0] in_r_r;
  reg  [9:0]  os_cnt_r;
  reg  [6:0]  ref_cnt_r;
  reg         smp_tick_r;
  reg         fsref_tick_r;
  reg         half_r;
  reg  [9:0]  period;
  reg  [15:0] de_b0;
  reg  [15:0] de_b1;
  reg  [15:0] de_a1;
  wire        deemph_ok;
  wire        fx_switch;
  wire        step;
  wire [7:0]  cur_w [0:1];
  wire [1:0]  st_w [0:1];
  wire        done_w [0:1];
  wire [15:0] dac_w [0:1];
  wire        dir;
  wire        pst_l;
  wire        pst_r;
  wire [6:0]  coef_idx;
  integer     k;

  assign coef_idx = i_reg_addr - `SDP_REG_COEF0;

  always @*
  begin
    case (div_code_r)
      3'h0: period = `SDP_PER_D0;
      3'h1: period = `SDP_PER_D1;
      3'h2: period = `SDP_PER_D2;
      3'h3: period = `SDP_PER_D3;
      3'h4: period = `SDP_PER_D4;
      3'h5: period = `SDP_PER_D5;
      3'h6: period = `SDP_PER_D6;
      default: period = `SDP_PER_D7;
    endcase
  end

  // The upsampled tick is the fixed-rate timebase; every sample rate divides it.
  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      os_cnt_r <= 10'h000;
      ref_cnt_r <= 7'h00;
      smp_tick_r <= 1'b0;
      fsref_tick_r <= 1'b0;
      half_r <= 1'b0;
      o_dac_valid <= 1'b0;
    end
    else
    begin
      smp_tick_r <= i_os_tick && (os_cnt_r == period - 10'h001);
      fsref_tick_r <= i_os_tick && (ref_cnt_r == `SDP_OS_PER_FSREF);
      o_dac_valid <= i_os_tick;
      if (i_os_tick)
      begin
        os_cnt_r <= (os_cnt_r >= period - 10'h001) ? 10'h000 : os_cnt_r + 10'h001;
        ref_cnt_r <= ref_cnt_r + 7'h01;
      end
      if (smp_tick_r)
        half_r <= ~half_r;
    end
  end

  assign o_smp_req = smp_tick_r;
  assign step = smp_tick_r && (!slow_r || half_r);

  assign deemph_ok = (div_code_r == `SDP_DIV_1)
                   || (div_code_r == `SDP_DIV_1P5 && !i_fsref_441);

  always @*
  begin
    if (div_code_r == `SDP_DIV_1P5)
    begin
      de_b0 = `SDP_DE32_B0;
      de_b1 = `SDP_DE32_B1;
      de_a1 = `SDP_DE32_A1;
    end
    else if (i_fsref_441)
    begin
      de_b0 = `SDP_DE44_B0;
      de_b1 = `SDP_DE44_B1;
      de_a1 = `SDP_DE44_A1;
    end
    else
    begin
      de_b0 = `SDP_DE48_B0;
      de_b1 = `SDP_DE48_B1;
      de_a1 = `SDP_DE48_A1;
    end
  end

  assign fx_switch = (deemph_req_r != deemph_act_r) || (fx_req_r != fx_act_r);

  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      div_code_r <= 3'h0;
      vol_l_r <= 8'h00;
      vol_r_r <= 8'h00;
      slow_r <= 1'b0;
      ss_dis_r <= 1'b0;
      deemph_req_r <= 1'b0;
      fx_req_r <= 1'b0;
      deemph_act_r <= 1'b0;
      fx_act_r <= 1'b0;
      pwr_l_r <= 1'b0;
      pwr_r_r <= 1'b0;
      up_dly_r <= `SDP_UPDLY_RST;
      in_l_r <= 16'h0000;
      in_r_r <= 16'h0000;
      for (k = 0; k < 20; k = k + 1)
      begin
        case (k % `SDP_NCOEF)
          0: coef_r[k] <= `SDP_B0_RST;
          1: coef_r[k] <= `SDP_B1_RST;
          2: coef_r[k] <= `SDP_B2_RST;
          3: coef_r[k] <= `SDP_A1_RST;
          default: coef_r[k] <= `SDP_A2_RST;
        endcase
      end
    end
    else
    begin
      if (i_smp_valid)
      begin
        in_l_r <= i_smp_l;
        in_r_r <= i_smp_r;
      end
      // Filter changes wait until both channels have stepped down to mute.
      if (fx_switch && cur_w[0] == `SDP_MUTE_IDX && cur_w[1] == `SDP_MUTE_IDX)
      begin
        deemph_act_r <= deemph_req_r;
        fx_act_r <= fx_req_r;
      end
      if (i_reg_wr)
      begin
        case (i_reg_addr)
          `SDP_REG_RATE: div_code_r <= i_reg_wdata[`SDP_DIV_MSB:`SDP_DIV_LSB];
          `SDP_REG_VOLS:
          begin
            vol_l_r <= i_reg_wdata[15:8];
            vol_r_r <= i_reg_wdata[7:0];
          end
          `SDP_REG_MVOL:
          begin
            vol_l_r <= i_reg_wdata[7:0];
            vol_r_r <= i_reg_wdata[7:0];
          end
          `SDP_REG_STEP: slow_r <= i_reg_wdata[`SDP_SLOW_BIT];
          `SDP_REG_SSDIS: ss_dis_r <= i_reg_wdata[`SDP_SSDIS_BIT];
          `SDP_REG_CTRL:
          begin
            deemph_req_r <= i_reg_wdata[`SDP_CTL_DEEMPH];
            fx_req_r <= i_reg_wdata[`SDP_CTL_FX];
            pwr_l_r <= i_reg_wdata[`SDP_CTL_PWR_L];
            pwr_r_r <= i_reg_wdata[`SDP_CTL_PWR_R];
          end
          `SDP_REG_UPDLY: up_dly_r <= i_reg_wdata;
          default:
          begin
            if (i_reg_addr >= `SDP_REG_COEF0 && i_reg_addr < `SDP_REG_COEF_END)
              coef_r[coef_idx[4:0]] <= i_reg_wdata;
          end
        endcase
      end
    end
  end

  assign dir = ~(pwr_l_r | pwr_r_r);
  assign pst_l = dir ? (st_w[0] == `SDP_PST_OFF) : (st_w[0] == `SDP_PST_UP);
  assign pst_r = dir ? (st_w[1] == `SDP_PST_OFF) : (st_w[1] == `SDP_PST_UP);

  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_reg_rdata <= 16'h0000;
    else if (!i_reg_rd)
      o_reg_rdata <= 16'h0000;
    else
    begin
      case (i_reg_addr)
        `SDP_REG_RATE: o_reg_rdata <= {10'h000, div_code_r, 3'h0};
        `SDP_REG_VOLS: o_reg_rdata <= {vol_l_r, vol_r_r};
        `SDP_REG_MVOL: o_reg_rdata <= {8'h00, vol_l_r};
        `SDP_REG_STEP: o_reg_rdata <= {12'h000, done_w[0], done_w[1], slow_r, 1'b0};
        `SDP_REG_PSTAT: o_reg_rdata <= {5'h00, dir, 5'h00, pst_l, pst_r, 3'h0};
        `SDP_REG_SSDIS: o_reg_rdata <= {1'b0, ss_dis_r, 14'h0000};
        `SDP_REG_CTRL: o_reg_rdata <= {12'h000, pwr_r_r, pwr_l_r, fx_req_r, deemph_req_r};
        `SDP_REG_UPDLY: o_reg_rdata <= up_dly_r;
        default:
        begin
          if (i_reg_addr >= `SDP_REG_COEF0 && i_reg_addr < `SDP_REG_COEF_END)
            o_reg_rdata <= coef_r[coef_idx[4:0]];
          else
            o_reg_rdata <= 16'h0000;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
      wire [15:0] de_y;
      wire [15:0] bq1_y;
      wire [15:0] bq2_y;
      wire [7:0]  q_idx;
      wire [7:0]  r_idx;
      wire signed [32:0] vp;
      reg  [15:0] frac;
      reg  [15:0] gain;
      reg  [15:0] vol_y_r;
      reg  [15:0] dly_r [0:`SDP_DLY_TAPS-1];
      reg  [15:0] out_r;
      wire signed [16:0] diff;
      wire signed [16:0] nxt;
      integer j;

      sdp_vol_ctl u_vol (
        .i_core_clk   (i_core_clk),
        .i_sys_rst    (i_sys_rst),
        .i_step       (step),
        .i_ss_dis     (ss_dis_r),
        .i_req_idx    (g == 0 ? vol_l_r : vol_r_r),
        .i_force_mute (fx_switch),
        .i_pwr_req    (g == 0 ? pwr_l_r : pwr_r_r),
        .i_fsref_tick (fsref_tick_r),
        .i_up_dly     (up_dly_r),
        .o_cur_idx    (cur_w[g]),
        .o_state      (st_w[g]),
        .o_done       (done_w[g])
      );

      sdp_biquad u_de (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_en       (smp_tick_r),
        .i_byp      (~(deemph_act_r & deemph_ok)),
        .i_x        (g == 0 ? in_l_r : in_r_r),
        .i_b0       (de_b0),
        .i_b1       (de_b1),
        .i_b2       (`SDP_ZERO16),
        .i_a1       (de_a1),
        .i_a2       (`SDP_ZERO16),
        .o_y        (de_y)
      );

      sdp_biquad u_bq1 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_en       (smp_tick_r),
        .i_byp      (~fx_act_r),
        .i_x        (de_y),
        .i_b0       (coef_r[g*`SDP_CH_COEFS]),
        .i_b1       (coef_r[g*`SDP_CH_COEFS+1]),
        .i_b2       (coef_r[g*`SDP_CH_COEFS+2]),
        .i_a1       (coef_r[g*`SDP_CH_COEFS+3]),
        .i_a2       (coef_r[g*`SDP_CH_COEFS+4]),
        .o_y        (bq1_y)
      );

      sdp_biquad u_bq2 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_en       (smp_tick_r),
        .i_byp      (~fx_act_r),
        .i_x        (bq1_y),
        .i_b0       (coef_r[g*`SDP_CH_COEFS+5]),
        .i_b1       (coef_r[g*`SDP_CH_COEFS+6]),
        .i_b2       (coef_r[g*`SDP_CH_COEFS+7]),
        .i_a1       (coef_r[g*`SDP_CH_COEFS+8]),
        .i_a2       (coef_r[g*`SDP_CH_COEFS+9]),
        .o_y        (bq2_y)
      );

      assign q_idx = cur_w[g] / `SDP_STEPS_6DB;
      assign r_idx = cur_w[g] % `SDP_STEPS_6DB;

      always @*
      begin
        case (r_idx)
          8'h00: frac = `SDP_GAIN_0;
          8'h01: frac = `SDP_GAIN_1;
          8'h02: frac = `SDP_GAIN_2;
          8'h03: frac = `SDP_GAIN_3;
          8'h04: frac = `SDP_GAIN_4;
          8'h05: frac = `SDP_GAIN_5;
          8'h06: frac = `SDP_GAIN_6;
          8'h07: frac = `SDP_GAIN_7;
          8'h08: frac = `SDP_GAIN_8;
          8'h09: frac = `SDP_GAIN_9;
          8'h0A: frac = `SDP_GAIN_10;
          default: frac = `SDP_GAIN_11;
        endcase
        gain = (cur_w[g] >= `SDP_MUTE_IDX) ? 16'h0000 : (frac >> q_idx);
      end

      assign vp = $signed(bq2_y) * $signed({1'b0, gain});
      assign diff = $signed(dly_r[`SDP_DLY_TAPS-1]) - $signed(out_r);
      assign nxt = $signed(out_r) + (diff >>> `SDP_INTERP_SH);

      // Volume stage, then a delay line that brings the sample path to 21 periods.
      always @(posedge i_core_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          vol_y_r <= 16'h0000;
          out_r <= 16'h0000;
          for (j = 0; j < `SDP_DLY_TAPS; j = j + 1)
            dly_r[j] <= 16'h0000;
        end
        else
        begin
          if (smp_tick_r)
          begin
            vol_y_r <= vp[30:15];
            dly_r[0] <= vol_y_r;
            for (j = 1; j < `SDP_DLY_TAPS; j = j + 1)
              dly_r[j] <= dly_r[j-1];
          end
          if (i_os_tick)
            out_r <= nxt[15:0];
        end
      end

      assign dac_w[g] = out_r;
    end
  endgenerate

  assign o_dac_l = dac_w[0];
  assign o_dac_r = dac_w[1];
  assign o_dac_pwr_l = (st_w[0] != `SDP_PST_OFF);
  assign o_dac_pwr_r = (st_w[1] != `SDP_PST_OFF);
endmodule
`default_nettype wire
